// File: design/i2c_host_consts.vh
// constants for the two-wire host that reaches the battery monitor target
// How it works
// R01 - bytes are eight bits, msb first, each followed by one acknowledge bit
// R02 - target keeps multi-byte values msb first, msb at the even address
// R03 - target acknowledges after the direction bit only when the address matches
// R04 - target address is 1001000 at power-up; only low three bits change
// R05 - direction 0 means host writes, direction 1 means target sends
// R06 - target works at any clock up to 400kHz without configuration
// R07 - the receiver acknowledges every byte before the next begins
// R08 - host may probe presence with START, address, direction and sampled ack
// R09 - first written byte is the pointer; data goes to pointer, pointer plus one
// R10 - on writes the host drives data except in the acknowledge cycles
// R11 - reads first write address and pointer, then repeated START, address, read
// R12 - in reads the target drives data bits; the host owns only acknowledge cycles
// R13 - host answers the last wanted byte with not-acknowledge; target then releases
// R14 - host ends writes with STOP or repeated START after the last acknowledge
// R15 - target advances its pointer after the last bit of each written byte
// R16 - writes running past FFh are discarded by the target
// R17 - target discards writes to read-only and reserved locations
// R18 - target never commits a cut-short or unacknowledged byte
// R19 - target sends msb first and advances pointer after each byte sent
// R20 - reads past FFh return FFh
// R21 - reserved locations may read back as anything
// R22 - host may end a read after any whole byte with not-acknowledge then STOP
// R23 - target latches both bytes of a pair when the upper one is read
// R24 - low address bits come from bits 2 to 0 of the register at 01
// R25 - acknowledge holds data low around the ninth clock high; nak leaves it high
// R26 - data changes only while clock is low, except START and STOP
// R27 - a target whose address does not match stays released until next START
`ifndef I2C_HOST_CONSTS_VH
`define I2C_HOST_CONSTS_VH
`define TGT_ADDR_RESET   7'h48
`define CFG_REG_ADDR     8'h01
`define ADDR_LOW_LSB     0
`define ADDR_LOW_MSB     2
`define SCL_PERIOD_NS    2500
`define CLK_PERIOD_NS    10
// rounded up, so the bus clock never runs faster than its limit
`define QTR_CYCLES       ((`SCL_PERIOD_NS / `CLK_PERIOD_NS + 3) / 4)
`define FIFO_DEPTH_DEF   32
`define RD_OP            1'b1
`define WR_OP            1'b0
`endif

// File: design/byte_fifo.v
// synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_ff;
  reg [AW-1:0]    rdPtr_ff;
  reg [AW:0]      count_ff;
  wire            doWr;
  wire            doRd;

  assign inReady  = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_ff];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + 1'b1;
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// File: design/i2c_host.v
// two-wire bus host: write bursts, pointer-then-read bursts and presence probes
`timescale 1ns/10ps
`include "i2c_host_consts.vh"
module i2c_host #(
  parameter QTR   = `QTR_CYCLES,
  parameter DEPTH = `FIFO_DEPTH_DEF
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire       cmdValid,
  output reg        cmdReady_ff,
  input  wire       cmdRead,
  input  wire       cmdProbe,
  input  wire [2:0] addressLowBits,
  input  wire [7:0] memoryPointerByte,
  input  wire [7:0] cmdLen,
  input  wire [7:0] wrData,
  input  wire       wrValid,
  output wire       wrReady,
  output reg  [7:0] rdData_ff,
  output reg        rdValid_ff,
  output reg        done_ff,
  output reg        nakSeen_ff,
  output reg        sclOut_ff,
  output reg        sclOe_ff,
  input  wire       sdaIn,
  output reg        sdaOut_ff,
  output reg        sdaOe_ff
);
  localparam S_IDLE = 4'h0, S_START = 4'h1, S_BIT = 4'h2, S_ACK = 4'h3;
  localparam S_NEXT = 4'h4, S_STOP = 4'h5, S_RSTART = 4'h6, S_FIN = 4'h7;
  localparam S_RBIT = 4'h8, S_MACK = 4'h9;
  // byte roles in the sequence
  localparam B_ADRW = 3'h0, B_PTR = 3'h1, B_DATA = 3'h2, B_ADRR = 3'h3;
  localparam [6:0] TGT_BASE = `TGT_ADDR_RESET;

  reg  [3:0]  state_ff;
  reg  [2:0]  role_ff;
  reg  [15:0] tick_ff;
  reg  [1:0]  phase_ff;
  reg  [2:0]  bitCnt_ff;
  reg  [7:0]  shift_ff;
  reg  [7:0]  left_ff;
  reg         isRead_ff;
  reg         isProbe_ff;
  reg  [6:0]  addr_ff;
  reg  [7:0]  ptr_ff;
  reg  [2:0]  sdaSync_ff;
  wire        sdaSampled;
  wire        qtrEnd;
  wire [7:0]  fifoData;
  wire        fifoValid;
  reg         fifoPop;

  // data pin passes three flops; value trusted once stage two and three agree
  always @(posedge mclk) begin
    if (rst) begin
      sdaSync_ff <= 3'h7;
    end else begin
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
    end
  end
  reg sdaStable_ff;
  always @(posedge mclk) begin
    if (rst) begin
      sdaStable_ff <= 1'b1;
    end else if (sdaSync_ff[1] == sdaSync_ff[2]) begin
      sdaStable_ff <= sdaSync_ff[2];
    end
  end
  assign sdaSampled = sdaStable_ff;

  // write data staged in a fifo; if it runs empty the host holds the clock low until the next byte
  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(5)) uFifo (
    .mclk     (mclk),
    .rst      (rst),
    .inData   (wrData),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  assign qtrEnd = (tick_ff == QTR[15:0] - 16'h0001);

  always @* begin
    fifoPop = (state_ff == S_NEXT) && (left_ff != 8'h00)
              && !isRead_ff && !isProbe_ff && fifoValid
              && (role_ff == B_PTR || role_ff == B_DATA);
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_ff    <= S_IDLE;
      role_ff     <= B_ADRW;
      tick_ff     <= 16'h0000;
      phase_ff    <= 2'h0;
      bitCnt_ff   <= 3'h0;
      shift_ff    <= 8'h00;
      left_ff     <= 8'h00;
      isRead_ff   <= 1'b0;
      isProbe_ff  <= 1'b0;
      addr_ff     <= `TGT_ADDR_RESET;
      ptr_ff      <= 8'h00;
      cmdReady_ff <= 1'b1;
      rdData_ff   <= 8'h00;
      rdValid_ff  <= 1'b0;
      done_ff     <= 1'b0;
      nakSeen_ff  <= 1'b0;
      sclOut_ff   <= 1'b1;
      sclOe_ff    <= 1'b0;
      sdaOut_ff   <= 1'b1;
      sdaOe_ff    <= 1'b0;
    end else begin
      rdValid_ff <= 1'b0;
      done_ff    <= 1'b0;
      tick_ff    <= qtrEnd ? 16'h0000 : tick_ff + 16'h0001;
      if (state_ff != S_IDLE && qtrEnd) begin
        phase_ff <= phase_ff + 2'h1;
      end
      case (state_ff)
        S_IDLE: begin
          tick_ff  <= 16'h0000;
          phase_ff <= 2'h0;
          sclOe_ff <= 1'b0;
          sdaOe_ff <= 1'b0;
          if (cmdValid) begin
            cmdReady_ff <= 1'b0;
            isRead_ff   <= cmdRead;
            isProbe_ff  <= cmdProbe;
            // a stale role would turn the first start into a read
            role_ff     <= B_ADRW;
            // upper four bits fixed; target may move only the low three
            addr_ff     <= {TGT_BASE[6:3], addressLowBits}; // R04 R24
            ptr_ff      <= memoryPointerByte;
            left_ff     <= cmdLen;
            nakSeen_ff  <= 1'b0;
            state_ff    <= S_START;
          end
        end
        // data falls while clock is high, then clock falls
        S_START: begin
          sclOe_ff <= 1'b1;
          sdaOe_ff <= 1'b1;
          if (qtrEnd) begin
            case (phase_ff)
              2'h0: sdaOut_ff <= 1'b0; // R26
              2'h1: sclOut_ff <= 1'b0;
              default: begin
                role_ff   <= (state_ff == S_START && isRead_ff && role_ff == B_PTR) ?
                             B_ADRR : B_ADRW;
                shift_ff  <= (isRead_ff && role_ff == B_PTR) ?
                             {addr_ff, `RD_OP} : {addr_ff, `WR_OP}; // R05 R11
                bitCnt_ff <= 3'h0;
                phase_ff  <= 2'h0;
                state_ff  <= S_BIT;
              end
            endcase
          end
        end
        // host drives each bit, msb first, changing only while clock is low
        S_BIT: begin
          if (qtrEnd) begin
            case (phase_ff)
              2'h0: begin
                sdaOe_ff  <= 1'b1;
                sdaOut_ff <= shift_ff[7]; // R01 R10 R26
              end
              2'h1: sclOut_ff <= 1'b1;
              2'h2: sclOut_ff <= 1'b1;
              default: begin
                sclOut_ff <= 1'b0;
                shift_ff  <= {shift_ff[6:0], 1'b0};
                bitCnt_ff <= bitCnt_ff + 3'h1;
                if (bitCnt_ff == 3'h7) begin
                  state_ff <= S_ACK;
                end
              end
            endcase
          end
        end
        // ninth clock: release data and sample the target's answer
        S_ACK: begin
          if (qtrEnd) begin
            case (phase_ff)
              2'h0: sdaOe_ff <= 1'b0; // R07 R25
              2'h1: sclOut_ff <= 1'b1;
              2'h2: nakSeen_ff <= sdaSampled; // R03 R08
              default: begin
                sclOut_ff <= 1'b0;
                state_ff  <= (nakSeen_ff || isProbe_ff) ? S_STOP : S_NEXT; // R08 R27
              end
            endcase
          end
        end
        S_NEXT: begin
          phase_ff  <= 2'h0;
          tick_ff   <= 16'h0000;
          bitCnt_ff <= 3'h0;
          if (role_ff == B_ADRW) begin
            role_ff  <= B_PTR;
            shift_ff <= ptr_ff; // R09 R11
            state_ff <= S_BIT;
          end else if (role_ff == B_PTR && isRead_ff) begin
            // pointer set; turn round with a repeated start
            state_ff <= S_RSTART; // R11
          end else if (role_ff == B_ADRR || (role_ff == B_DATA && isRead_ff)) begin
            role_ff  <= B_DATA;
            state_ff <= (left_ff == 8'h00) ? S_STOP : S_RBIT;
          end else if (left_ff == 8'h00) begin
            state_ff <= S_STOP; // R14
          end else if (fifoValid) begin
            role_ff  <= B_DATA;
            shift_ff <= fifoData;
            left_ff  <= left_ff - 8'h01;
            state_ff <= S_BIT;
          end
        end
        S_RSTART: begin
          if (qtrEnd) begin
            case (phase_ff)
              2'h0: begin
                sdaOe_ff  <= 1'b1;
                sdaOut_ff <= 1'b1;
              end
              2'h1: sclOut_ff <= 1'b1;
              default: begin
                phase_ff <= 2'h0;
                state_ff <= S_START;
              end
            endcase
          end
        end
        // target owns data bits during the read portion
        S_RBIT: begin
          sdaOe_ff <= 1'b0; // R12
          if (qtrEnd) begin
            case (phase_ff)
              2'h1: sclOut_ff <= 1'b1;
              2'h2: shift_ff <= {shift_ff[6:0], sdaSampled}; // R19
              2'h3: begin
                sclOut_ff <= 1'b0;
                bitCnt_ff <= bitCnt_ff + 3'h1;
                if (bitCnt_ff == 3'h7) begin
                  rdData_ff  <= shift_ff;
                  rdValid_ff <= 1'b1;
                  left_ff    <= left_ff - 8'h01;
                  state_ff   <= S_MACK;
                end
              end
              default: sclOut_ff <= 1'b0;
            endcase
          end
        end
        // host acks all bytes but the last, which gets a nak
        S_MACK: begin
          if (qtrEnd) begin
            case (phase_ff)
              2'h0: begin
                sdaOe_ff  <= 1'b1;
                sdaOut_ff <= (left_ff == 8'h00); // R13 R22 R25
              end
              2'h1: sclOut_ff <= 1'b1;
              2'h2: sclOut_ff <= 1'b1;
              default: begin
                sclOut_ff <= 1'b0;
                sdaOe_ff  <= 1'b0;
                state_ff  <= S_NEXT;
              end
            endcase
          end
        end
        // data rises while clock is high
        S_STOP: begin
          if (qtrEnd) begin
            case (phase_ff)
              2'h0: begin
                sdaOe_ff  <= 1'b1;
                sdaOut_ff <= 1'b0;
              end
              2'h1: sclOut_ff <= 1'b1;
              2'h2: sdaOut_ff <= 1'b1; // R26
              default: state_ff <= S_FIN;
            endcase
          end
        end
        S_FIN: begin
          sdaOe_ff    <= 1'b0;
          sclOe_ff    <= 1'b0;
          done_ff     <= 1'b1;
          cmdReady_ff <= 1'b1;
          state_ff    <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// File: bench/tgt_model.sv
// behavioural battery-monitor target on the two-wire bus
`timescale 1ns/10ps
module tgt_model (
  input  wire scl,
  input  wire sda,
  output reg  pullLow
);
  reg [7:0] mem [0:255];
  reg [7:0] sh, ptr;
  reg [3:0] bc;
  reg       act, rd, adr, first, ackPh, nak, ovf;
  integer   k;
  initial begin
    for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0] ^ 8'h5A;
    mem[1] = 8'hC0;
    {sh, ptr, bc, act, rd, adr, first, ackPh, nak, ovf, pullLow} = '0;
  end
  // a new start always begins with an address byte, never in read mode
  always @(negedge sda) if (scl === 1'b1) {act, adr, rd, bc, ackPh, pullLow} = 9'h180;
  always @(posedge sda) if (scl === 1'b1) {act, pullLow} = 2'b00;
  // event driven, so any clock rate up to the bus limit works
  always @(posedge scl) if (act) begin
    if (ackPh) nak = sda;
    else begin
      if (adr || !rd) sh = {sh[6:0], sda};
      bc = bc + 4'h1;
    end
  end
  always @(negedge scl) if (act) begin
    if (ackPh) begin
      {ackPh, bc, pullLow} = '0;
      if (rd && nak) act = 0;
      else if (rd) begin
        sh = ovf ? 8'hFF : mem[ptr];
        pullLow = !sh[7];
      end
    end else if (bc == 4'h8) begin
      ackPh = 1;
      if (adr) begin
        {adr, rd, first} = {1'b0, sh[0], 1'b1};
        act = sh[7:1] == {4'h9, mem[1][2:0]};
        pullLow = act;
      end else if (rd) begin
        pullLow = 0;
        ovf = ovf | (ptr == 8'hFF);
        ptr = ptr + 8'h1;
      end else begin
        if (first) {ptr, ovf, first} = {sh, 2'b00};
        else begin
          if (!ovf && (ptr == 8'h01 || ptr[7:1] == 7'h08 || ptr == 8'h61 || ptr == 8'h62))
            mem[ptr] = sh;
          ovf = ovf | (ptr == 8'hFF);
          ptr = ptr + 8'h1;
        end
        pullLow = 1;
      end
    end else if (rd) pullLow = !sh[4'h7 - bc];
  end
endmodule

// File: bench/i2c_host_assertions.sv
// concurrent checks on the host's handshakes and pin drive
`timescale 1ns/10ps
module i2c_host_assertions #(
  parameter QTR = 6
) (
  input wire mclk,
  input wire rst,
  input wire cmdValid,
  input wire cmdReady_ff,
  input wire rdValid_ff,
  input wire done_ff,
  input wire sclOut_ff,
  input wire sclOe_ff,
  input wire sdaOut_ff,
  input wire sdaOe_ff
);
  wire      sclHi = !(sclOe_ff && !sclOut_ff);
  wire      sdaHi = !(sdaOe_ff && !sdaOut_ff);
  reg [7:0] hiCnt_ff;
  always @(posedge mclk) begin
    hiCnt_ff <= (rst || !sclHi) ? 8'h00 : hiCnt_ff + {7'h0, hiCnt_ff != 8'hFF};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    cmdValid && cmdReady_ff;
  endsequence
  a_take_busy: assert property (s_take |=> !cmdReady_ff)
    else $error("taken command left ready");
  a_done_pulse: assert property (done_ff |=> !done_ff)
    else $error("done longer than one cycle");
  a_rdv_pulse: assert property (rdValid_ff |=> !rdValid_ff)
    else $error("byte strobe too long");
  a_done_ready: assert property (done_ff |-> ##[0:1] cmdReady_ff)
    else $error("not ready after done");
  a_idle_free: assert property (cmdReady_ff |-> !sclOe_ff && !sdaOe_ff)
    else $error("idle pin driven");
  a_rdv_busy: assert property (rdValid_ff |-> !cmdReady_ff)
    else $error("read byte while idle");
  a_scl_high: assert property ($fell(sclHi) |-> hiCnt_ff >= QTR)
    else $error("clock high too short");
  a_stop_done: assert property (done_ff |-> $past(sclHi) && $past(sdaHi))
    else $error("no stop");
  // data may rise under a high clock only as the stop that ends a command
  a_rise_stop: assert property (sclHi && $past(sclHi) && $rose(sdaHi) |-> ##[1:300] done_ff)
    else $error("data rose under high clock");
endmodule
bind i2c_host i2c_host_assertions #(.QTR(QTR)) i_chk (
  .mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdReady_ff(cmdReady_ff),
  .rdValid_ff(rdValid_ff), .done_ff(done_ff), .sclOut_ff(sclOut_ff),
  .sclOe_ff(sclOe_ff), .sdaOut_ff(sdaOut_ff), .sdaOe_ff(sdaOe_ff));

// File: bench/i2c_host_test.sv
// self-checking bench: host against a behavioural target
`timescale 1ns/10ps
module i2c_host_test;
  logic       mclk, rst, cmdValid, cmdRead, cmdProbe, wrValid;
  logic [2:0] addressLowBits;
  logic [7:0] memoryPointerByte, cmdLen, wrData;
  wire        cmdReady_ff, wrReady, rdValid_ff, done_ff, nakSeen_ff, pullLow;
  wire        sclOut_ff, sclOe_ff, sdaOut_ff, sdaOe_ff;
  wire  [7:0] rdData_ff;
  wire        scl = !(sclOe_ff && !sclOut_ff);
  wire        sda = !((sdaOe_ff && !sdaOut_ff) || pullLow);
  int         n_errors = 0;
  int         tests_run = 0;
  logic [7:0] rq[$];
  i2c_host #(.QTR(6)) i_i2c_host (.mclk(mclk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady_ff(cmdReady_ff), .cmdRead(cmdRead), .cmdProbe(cmdProbe),
    .addressLowBits(addressLowBits), .memoryPointerByte(memoryPointerByte),
    .cmdLen(cmdLen), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
    .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff), .done_ff(done_ff),
    .nakSeen_ff(nakSeen_ff), .sclOut_ff(sclOut_ff), .sclOe_ff(sclOe_ff),
    .sdaIn(sda), .sdaOut_ff(sdaOut_ff), .sdaOe_ff(sdaOe_ff));
  tgt_model i_tgt_model (.scl(scl), .sda(sda), .pullLow(pullLow));
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk) if (rdValid_ff === 1'b1) rq.push_back(rdData_ff);
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task ran_out;
    n_errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    give_verdict;
  endtask
  task push(input logic [7:0] d);
    int k;
    for (k = 0; wrReady !== 1'b1; k++) begin
      if (k > 20000) ran_out;
      tick;
    end
    wrData = d;
    wrValid = 1;
    tick;
    wrValid = 0;
    tick;
  endtask
  // command inputs stay put until the next call, after the host took them
  task run(input logic r, p, input logic [2:0] a, input logic [7:0] ptr, n);
    int k;
    {cmdRead, cmdProbe, addressLowBits, memoryPointerByte, cmdLen} = {r, p, a, ptr, n};
    cmdValid = 1;
    k = 0;
    do begin tick; k++; end while (cmdReady_ff !== 1'b0 && k < 50);
    cmdValid = 0;
    while (done_ff !== 1'b1 && k < 30000) begin tick; k++; end
    if (k >= 30000) ran_out;
  endtask
  task t_probe;
    chk8({7'h0, cmdReady_ff}, 8'h01);
    run(0, 1, 3'h0, 8'h00, 8'h00);
    chk8({7'h0, nakSeen_ff}, 8'h00);
    run(0, 1, 3'h5, 8'h00, 8'h00);
    chk8({7'h0, nakSeen_ff}, 8'h01);
    $display("probe test done");
  endtask
  task t_burst;
    push(8'hA5);
    push(8'h3C);
    run(0, 0, 3'h0, 8'h10, 8'h02);
    chk8(i_tgt_model.mem[8'h10], 8'hA5);
    chk8(i_tgt_model.mem[8'h11], 8'h3C);
    rq.delete();
    run(1, 0, 3'h0, 8'h10, 8'h02);
    chk8(rq[0], 8'hA5);
    chk8(rq[1], 8'h3C);
    chk8(8'(rq.size()), 8'h02);
    $display("burst test done");
  endtask
  task t_edge;
    push(8'h77);
    run(0, 0, 3'h0, 8'h0A, 8'h01);
    chk8(i_tgt_model.mem[8'h0A], 8'h50);
    rq.delete();
    run(1, 0, 3'h0, 8'hFE, 8'h04);
    chk8(rq[1], 8'hA5);
    chk8(rq[3], 8'hFF);
    chk8(8'(rq.size()), 8'h04);
    $display("edge test done");
  endtask
  task t_stall;
    fork
      run(0, 0, 3'h0, 8'h61, 8'h02);
      // host reaches the first data byte well before this and must wait
      begin repeat (600) tick; push(8'h11); push(8'h22); end
    join
    chk8(i_tgt_model.mem[8'h61], 8'h11);
    chk8(i_tgt_model.mem[8'h62], 8'h22);
    $display("stall test done");
  endtask
  task t_fill;
    int k;
    for (k = 0; wrReady === 1'b1 && k < 40; k++) push(8'h80 + k[7:0]);
    chk8(k[7:0], 8'h20);
    run(0, 0, 3'h0, 8'h10, 8'h20);
    chk8(i_tgt_model.mem[8'h11], 8'h81);
    chk8(i_tgt_model.mem[8'h12], 8'h48);
    chk8({7'h0, wrReady}, 8'h01);
    $display("fill test done");
  endtask
  task t_addr;
    push(8'hC3);
    run(0, 0, 3'h0, 8'h01, 8'h01);
    run(0, 1, 3'h0, 8'h00, 8'h00);
    chk8({7'h0, nakSeen_ff}, 8'h01);
    rq.delete();
    run(1, 0, 3'h3, 8'h01, 8'h01);
    chk8(rq[0], 8'hC3);
    chk8({7'h0, nakSeen_ff}, 8'h00);
    $display("address test done");
  endtask
  initial begin
    {rst, cmdValid, cmdRead, cmdProbe, wrValid} = 5'b10000;
    {addressLowBits, memoryPointerByte, cmdLen, wrData} = '0;
    repeat (3) @(posedge mclk);
    #1 rst = 0;
    t_probe;
    t_burst;
    t_edge;
    t_stall;
    t_fill;
    t_addr;
    give_verdict;
  end
endmodule
